// File: common/wdt_pkg.sv
// Package: offsets, field layouts, reset values and tables for the independent watchdog
package wdt_pkg;
  localparam logic [3:0]  ADDR_REFRESH  = 4'h0;
  localparam logic [3:0]  ADDR_CONTROL  = 4'h1;
  localparam logic [3:0]  ADDR_RSTCTL   = 4'h2;
  localparam logic [3:0]  ADDR_STOPCTL  = 4'h3;
  localparam logic [3:0]  ADDR_STATUS   = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0]  ADDR_IRQ_MASK = 4'h6;
  localparam logic [7:0]  REFRESH_FIRST  = 8'h00;
  localparam logic [7:0]  REFRESH_SECOND = 8'hFF;
  localparam int CTL_CKS_LSB  = 0;
  localparam int CTL_TIMEOUT_PERIOD_SEL_LSB = 4;
  localparam int CTL_WINDOW_START_SEL_LSB = 6;
  localparam int CTL_WINDOW_END_SEL_LSB = 8;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam int IRQ_UNDERFLOW = 0;
  localparam int IRQ_REFRESH_ERR = 1;
  localparam int COUNT_WIDTH = 14;

  typedef struct packed {
    logic [3:0] clock_divide_sel;
    logic [1:0] timeout_period_sel;
    logic [1:0] window_start_sel;
    logic [1:0] window_end_sel;
    logic       reset_or_irq_sel;
    logic       lowpower_stop_en;
  } config_type;

  typedef struct packed {
    logic       auto_start;
    config_type option;
  } option_word_type;

  typedef enum logic [1:0] {ST_STOPPED, ST_ARMED, ST_COUNTING} state_type;

  // Divide code to log2 ratio: 0->1, 2->16, 3->32, 4->64, 15->128, 5->256
  function automatic logic [3:0] divide_shift(input logic [3:0] code);
    case (code)
      4'h2:    divide_shift = 4'h4;
      4'h3:    divide_shift = 4'h5;
      4'h4:    divide_shift = 4'h6;
      4'hF:    divide_shift = 4'h7;
      4'h5:    divide_shift = 4'h8;
      default: divide_shift = 4'h0;
    endcase
  endfunction

  // Timeout code to start count: 128, 512, 1024, 2048 cycles minus one
  function automatic logic [13:0] timeout_count(input logic [1:0] code);
    case (code)
      2'h0:    timeout_count = 14'h007F;
      2'h1:    timeout_count = 14'h01FF;
      2'h2:    timeout_count = 14'h03FF;
      default: timeout_count = 14'h07FF;
    endcase
  endfunction

  // Window position code to percent of period, as a count threshold
  function automatic logic [13:0] window_point(input logic [1:0] code, input logic [13:0] top);
    case (code)
      2'h0:    window_point = top - (top >> 2);
      2'h1:    window_point = top >> 1;
      2'h2:    window_point = top >> 2;
      default: window_point = top;
    endcase
  endfunction
endpackage

// File: src/independent_watchdog.sv
// Independent watchdog: prescaler, 14-bit down-counter, window check, event outputs
module independent_watchdog (
  input  wire logic                     mclk,
  input  wire logic                     reset,
  input  wire logic                     watchdog_dedicated_clock,
  input  wire wdt_pkg::option_word_type reset_option_word,
  input  wire logic                     low_power_entry,
  input  wire logic [3:0]               reg_addr,
  input  wire logic [15:0]              reg_wdata,
  input  wire logic                     reg_write,
  input  wire logic                     reg_read,
  output logic      [15:0]              reg_rdata,
  output logic                          wdt_reset_out,
  output logic                          wdt_nmi_request,
  output logic                          underflow_event,
  output logic                          refresh_error_event,
  output logic                          sleep_count_stop,
  output logic                          irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0]              control_reg;
  logic                     reset_or_irq_sel;
  logic                     lowpower_stop_en;
  wdt_pkg::config_type      active_cfg;
  wdt_pkg::state_type       state;
  logic [13:0]              count;
  logic [7:0]               prescale;
  logic                     clk_d1;
  logic                     clk_d2;
  logic                     clk_d3;
  logic                     first_seen;
  logic [1:0]               irq_stat;
  logic [1:0]               irq_mask;
  logic                     auto_mode;
  logic                     started;
  logic                     src_edge;
  logic                     tick;
  logic                     refresh_ok;
  logic                     in_window;
  logic                     err_refresh;
  logic                     underflow;
  logic                     halted;
  logic [13:0]              top;
  logic [13:0]              win_hi;
  logic [13:0]              win_lo;
  logic [7:0]               div_mask;
  wdt_pkg::config_type      reg_cfg;

  assign auto_mode = reset_option_word.auto_start;
  assign reg_cfg   = '{clock_divide_sel:   control_reg[wdt_pkg::CTL_CKS_LSB +: 4],
                       timeout_period_sel: control_reg[wdt_pkg::CTL_TIMEOUT_PERIOD_SEL_LSB +: 2],
                       window_start_sel:   control_reg[wdt_pkg::CTL_WINDOW_START_SEL_LSB +: 2],
                       window_end_sel:     control_reg[wdt_pkg::CTL_WINDOW_END_SEL_LSB +: 2],
                       reset_or_irq_sel:   reset_or_irq_sel,
                       lowpower_stop_en:   lowpower_stop_en};

  ////////////////////////////////////////////////////////////////////////////
  // Dedicated clock sampled as a level; first stage read only by the second
  always_ff @(posedge mclk) begin
    if (reset) begin
      clk_d1 <= 1'b0;
      clk_d2 <= 1'b0;
      clk_d3 <= 1'b0;
    end else begin
      clk_d1 <= watchdog_dedicated_clock;
      clk_d2 <= clk_d1;
      clk_d3 <= clk_d2;
    end
  end
  assign src_edge = clk_d2 & ~clk_d3;

  assign halted   = active_cfg.lowpower_stop_en & low_power_entry;
  assign div_mask = 8'((9'h001 << wdt_pkg::divide_shift(active_cfg.clock_divide_sel)) - 9'h001);
  // Prescaler restarts with each reload so the first tick is a full period
  always_ff @(posedge mclk) begin
    if (reset || state != wdt_pkg::ST_COUNTING || refresh_ok) begin
      prescale <= 8'h00;
    end else if (src_edge && !halted) begin
      prescale <= (prescale == div_mask) ? 8'h00 : prescale + 8'h01;
    end
  end
  assign tick = src_edge && !halted && (prescale == div_mask) &&
                state == wdt_pkg::ST_COUNTING;

  ////////////////////////////////////////////////////////////////////////////
  // Window: permitted while count is between end and start positions
  assign top     = wdt_pkg::timeout_count(active_cfg.timeout_period_sel);
  assign win_hi  = wdt_pkg::window_point(active_cfg.window_start_sel, top);
  assign win_lo  = (active_cfg.window_end_sel == 2'h3) ? 14'h0000 :
                   wdt_pkg::window_point(2'(active_cfg.window_end_sel + 2'h1), top);
  assign in_window = (count <= win_hi) && (count >= win_lo);

  wire write_refresh = reg_write && reg_addr == wdt_pkg::ADDR_REFRESH;
  wire pair_done     = write_refresh && first_seen &&
                       reg_wdata[7:0] == wdt_pkg::REFRESH_SECOND;
  assign refresh_ok  = pair_done && (state != wdt_pkg::ST_COUNTING || in_window);
  assign err_refresh = pair_done && state == wdt_pkg::ST_COUNTING && !in_window;
  assign underflow   = tick && count == 14'h0000;

  always_ff @(posedge mclk) begin
    if (reset) begin
      first_seen <= 1'b0;
    end else if (write_refresh) begin
      first_seen <= reg_wdata[7:0] == wdt_pkg::REFRESH_FIRST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count state machine
  always_ff @(posedge mclk) begin
    if (reset) begin
      state      <= wdt_pkg::ST_ARMED;
      count      <= '0;
      active_cfg <= '0;
      started    <= 1'b0;
    end else begin
      unique case (state)
        wdt_pkg::ST_ARMED: begin
          // Option word is caught by a clocked process after release
          if (auto_mode) begin
            active_cfg <= reset_option_word.option;
            count      <= wdt_pkg::timeout_count(reset_option_word.option.timeout_period_sel);
            state      <= wdt_pkg::ST_COUNTING;
            started    <= 1'b1;
          end else begin
            state <= wdt_pkg::ST_STOPPED;
          end
        end
        wdt_pkg::ST_STOPPED: begin
          if (pair_done && !auto_mode) begin
            active_cfg <= reg_cfg;
            count      <= wdt_pkg::timeout_count(reg_cfg.timeout_period_sel);
            state      <= wdt_pkg::ST_COUNTING;
            started    <= 1'b1;
          end else if (auto_mode && started && !active_cfg.reset_or_irq_sel) begin
            count <= top;
            state <= wdt_pkg::ST_COUNTING;
          end
        end
        wdt_pkg::ST_COUNTING: begin
          if (underflow || err_refresh) begin
            state <= wdt_pkg::ST_STOPPED;
          end else if (refresh_ok) begin
            count <= top;
          end else if (tick) begin
            count <= count - 14'h0001;
          end
        end
        default: state <= wdt_pkg::ST_STOPPED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault outputs and event pulses
  wire fault = state == wdt_pkg::ST_COUNTING && (underflow || err_refresh);
  always_ff @(posedge mclk) begin
    if (reset) begin
      wdt_reset_out       <= 1'b0;
      wdt_nmi_request     <= 1'b0;
      underflow_event     <= 1'b0;
      refresh_error_event <= 1'b0;
      sleep_count_stop    <= 1'b0;
    end else begin
      wdt_reset_out       <= fault && active_cfg.reset_or_irq_sel;
      wdt_nmi_request     <= fault && !active_cfg.reset_or_irq_sel;
      underflow_event     <= state == wdt_pkg::ST_COUNTING && underflow;
      refresh_error_event <= err_refresh;
      sleep_count_stop    <= halted;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file; control writes only land before the first start
  always_ff @(posedge mclk) begin
    if (reset) begin
      control_reg      <= wdt_pkg::CONTROL_RESET;
      reset_or_irq_sel <= 1'b0;
      lowpower_stop_en <= 1'b0;
      irq_mask         <= 2'b00;
    end else if (reg_write) begin
      if (reg_addr == wdt_pkg::ADDR_CONTROL && !started) begin
        control_reg <= reg_wdata;
      end
      if (reg_addr == wdt_pkg::ADDR_RSTCTL && !started) begin
        reset_or_irq_sel <= reg_wdata[0];
      end
      if (reg_addr == wdt_pkg::ADDR_STOPCTL && !started) begin
        lowpower_stop_en <= reg_wdata[0];
      end
      if (reg_addr == wdt_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= reg_wdata[1:0];
      end
    end
  end

  // Sticky status: a new event wins over the read that clears
  wire [1:0] events = {err_refresh, state == wdt_pkg::ST_COUNTING && underflow};
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_stat <= 2'b00;
    end else if (reg_read && reg_addr == wdt_pkg::ADDR_IRQ_STAT) begin
      irq_stat <= events;
    end else begin
      irq_stat <= irq_stat | events;
    end
  end
  assign irq = |(irq_stat & irq_mask);

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      unique case (reg_addr)
        wdt_pkg::ADDR_CONTROL:  reg_rdata <= control_reg;
        wdt_pkg::ADDR_RSTCTL:   reg_rdata <= {15'h0000, reset_or_irq_sel};
        wdt_pkg::ADDR_STOPCTL:  reg_rdata <= {15'h0000, lowpower_stop_en};
        wdt_pkg::ADDR_STATUS:   reg_rdata <= {2'b00, count};
        wdt_pkg::ADDR_IRQ_STAT: reg_rdata <= {14'h0000, irq_stat};
        wdt_pkg::ADDR_IRQ_MASK: reg_rdata <= {14'h0000, irq_mask};
        default:                reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_reset_stops: assert property (@(posedge mclk) reset |=> !wdt_reset_out && !wdt_nmi_request)
    else $error("outputs active after reset");
  chk_underflow_stop: assert property (@(posedge mclk) disable iff (reset)
    underflow_event |-> state == wdt_pkg::ST_STOPPED) else $error("count continued");
  chk_tick_decrement: assert property (@(posedge mclk) disable iff (reset)
    tick && count != 0 && !refresh_ok && !err_refresh |=> count == $past(count) - 14'h0001)
    else $error("no decrement");
  chk_fault_select: assert property (@(posedge mclk) disable iff (reset)
    (underflow_event || refresh_error_event) |-> (wdt_reset_out ^ wdt_nmi_request))
    else $error("fault output wrong");
  chk_window_error: assert property (@(posedge mclk) disable iff (reset)
    err_refresh |=> refresh_error_event && state == wdt_pkg::ST_STOPPED)
    else $error("window error missed");
  chk_halt_freeze: assert property (@(posedge mclk) disable iff (reset)
    state == wdt_pkg::ST_COUNTING && halted && !refresh_ok |=> $stable(count))
    else $error("counted in low power");
  chk_auto_start: assert property (@(posedge mclk) disable iff (reset)
    state == wdt_pkg::ST_ARMED && auto_mode |=> state == wdt_pkg::ST_COUNTING)
    else $error("no auto start");
  chk_reg_start: assert property (@(posedge mclk) disable iff (reset)
    state == wdt_pkg::ST_STOPPED && !auto_mode && !pair_done |=> state != wdt_pkg::ST_COUNTING)
    else $error("started without refresh");
  cov_underflow:  cover property (@(posedge mclk) underflow_event);
  cov_win_error:  cover property (@(posedge mclk) refresh_error_event);
  cov_refresh:    cover property (@(posedge mclk) refresh_ok && state == wdt_pkg::ST_COUNTING);
endmodule // independent_watchdog

// File: verification/tb.sv
// Self-checking testbench for the independent watchdog
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    mclk;
  logic                    reset;
  logic                    dclk;
  logic                    low_power_entry;
  logic                    reg_write;
  logic                    reg_read;
  logic [3:0]              reg_addr;
  logic [15:0]             reg_wdata;
  logic [15:0]             reg_rdata;
  logic [15:0]             rd;
  logic                    wdt_reset_out;
  logic                    wdt_nmi_request;
  logic                    underflow_event;
  logic                    refresh_error_event;
  logic                    sleep_count_stop;
  logic                    irq;
  logic                    seen_uf;
  logic                    seen_re;
  logic                    seen_rst;
  logic                    seen_nmi;
  wdt_pkg::option_word_type opt;
  int                      num_errors;
  int                      comparisons;

  independent_watchdog dut_u (
    .mclk                     (mclk),
    .reset                    (reset),
    .watchdog_dedicated_clock (dclk),
    .reset_option_word        (opt),
    .low_power_entry          (low_power_entry),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_write                (reg_write),
    .reg_read                 (reg_read),
    .reg_rdata                (reg_rdata),
    .wdt_reset_out            (wdt_reset_out),
    .wdt_nmi_request          (wdt_nmi_request),
    .underflow_event          (underflow_event),
    .refresh_error_event      (refresh_error_event),
    .sleep_count_stop         (sleep_count_stop),
    .irq                      (irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // One-cycle pulses are latched so a scenario can judge them afterwards
  always @(posedge mclk) begin
    if (underflow_event === 1'b1) seen_uf <= 1'b1;
    if (refresh_error_event === 1'b1) seen_re <= 1'b1;
    if (wdt_reset_out === 1'b1) seen_rst <= 1'b1;
    if (wdt_nmi_request === 1'b1) seen_nmi <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge mclk);
    reset <= 1'b1;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    seen_uf = 1'b0; seen_re = 1'b0; seen_rst = 1'b0; seen_nmi = 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_read <= 1'b1; reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic refresh();
    wr(wdt_pkg::ADDR_REFRESH, 16'h0000);
    wr(wdt_pkg::ADDR_REFRESH, 16'h00FF);
  endtask

  // Dedicated clock is kept well below half the bus clock so every edge is seen
  task automatic ticks(input int n);
    repeat (n) begin
      repeat (3) @(posedge mclk);
      dclk <= 1'b1;
      repeat (3) @(posedge mclk);
      dclk <= 1'b0;
    end
    repeat (4) @(posedge mclk);
  endtask

  task automatic status_is(input logic [15:0] exp);
    rd_reg(wdt_pkg::ADDR_STATUS, rd);
    check(rd, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic scen_register_mode();
    opt = '0;
    do_reset();
    rd_reg(wdt_pkg::ADDR_CONTROL, rd);
    check(rd, wdt_pkg::CONTROL_RESET);
    rd_reg(4'hF, rd);
    check(rd, 16'h0000);
    wr(wdt_pkg::ADDR_IRQ_MASK, 16'h0003);
    wr(wdt_pkg::ADDR_CONTROL, 16'h03C0);
    wr(wdt_pkg::ADDR_RSTCTL, 16'h0000);
    wr(wdt_pkg::ADDR_REFRESH, 16'h00FF);
    ticks(2);
    status_is(16'h0000);
    refresh();
    status_is(16'h007F);
    ticks(5);
    status_is(16'h007A);
    // Configuration is frozen once counting has started
    wr(wdt_pkg::ADDR_CONTROL, 16'h03F0);
    refresh();
    status_is(16'h007F);
    seen_uf = 1'b0;
    ticks(127);
    status_is(16'h0000);
    check(seen_uf, 1'b0);
    ticks(1);
    check(seen_uf, 1'b1);
    check(seen_nmi, 1'b1);
    check(seen_rst, 1'b0);
    check(irq, 1'b1);
    rd_reg(wdt_pkg::ADDR_IRQ_STAT, rd);
    check(rd, 16'h0001);
    check(irq, 1'b0);
    ticks(3);
    status_is(16'h0000);
    refresh();
    status_is(16'h007F);
  endtask

  task automatic scen_refresh_error();
    opt = '0;
    do_reset();
    status_is(16'h0000);
    wr(wdt_pkg::ADDR_CONTROL, 16'h0380);
    wr(wdt_pkg::ADDR_RSTCTL, 16'h0001);
    refresh();
    status_is(16'h007F);
    // Count 7F sits above the 25 percent window start, so this refresh is early
    refresh();
    // Event pulse lands one edge later and the latch one edge after that
    repeat (2) @(posedge mclk);
    check(seen_re, 1'b1);
    check(seen_rst, 1'b1);
    check(seen_nmi, 1'b0);
    check(seen_uf, 1'b0);
    rd_reg(wdt_pkg::ADDR_IRQ_STAT, rd);
    check(rd, 16'h0002);
    ticks(2);
    status_is(16'h007F);
  endtask

  task automatic scen_auto_start();
    opt = '0;
    opt.auto_start = 1'b1;
    opt.option.clock_divide_sel = 4'h2;
    opt.option.timeout_period_sel = 2'h1;
    opt.option.window_start_sel = 2'h3;
    opt.option.window_end_sel = 2'h3;
    opt.option.lowpower_stop_en = 1'b1;
    do_reset();
    repeat (2) @(posedge mclk);
    status_is(16'h01FF);
    ticks(15);
    status_is(16'h01FF);
    ticks(1);
    status_is(16'h01FE);
    low_power_entry <= 1'b1;
    repeat (3) @(posedge mclk);
    check(sleep_count_stop, 1'b1);
    ticks(16);
    status_is(16'h01FE);
    low_power_entry <= 1'b0;
    repeat (3) @(posedge mclk);
    check(sleep_count_stop, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    num_errors = 0;
    comparisons = 0;
    reset = 1'b1;
    dclk = 1'b0;
    low_power_entry = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    opt = '0;
    scen_register_mode();
    scen_refresh_error();
    scen_auto_start();
    close_out();
  end

  // Scenarios take about 1200 cycles; this limit leaves ample margin
  initial begin
    #400000;
    num_errors++;
    close_out();
  end
endmodule // tb
